/* logic/hwrs_sequencer.sv */
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hwrs_sequencer
  import hwrs_pkg::*;
#(
  parameter int PA_WIDTH  = 8,  // port A pins with wake capability
  parameter int INT_COUNT = 4   // interrupt sources
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // processor core
  input  wire hwrs_core_in_type     coreIn,
  input  wire logic [INT_COUNT-1:0] intReq,
  input  wire logic [INT_COUNT-1:0] intEnable,
  output hwrs_ctrl_out_type         ctrlOut,
  // pins, asynchronous to clk
  input  wire logic                 extResetPin_n,
  input  wire logic                 lowVoltage,
  input  wire logic [PA_WIDTH-1:0]  portAPin
);

  if (PA_WIDTH < 1 || PA_WIDTH > 32 || INT_COUNT < 1 || INT_COUNT > 32) begin : gBadParam
    $error("sequencer widths out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  hwrs_state_type        state_reg;      // sequencer state
  hwrs_state_type        state_next;
  hwrs_cause_type        cause_reg;      // last wake source
  hwrs_cause_type        cause_next;
  logic                  takeInt_reg;    // wake will enter service
  logic                  takeInt_next;
  logic                  haltedAtRst_reg;  // reset arrived during power-down
  logic [7:0]            pdc_reg;        // power_down_control
  logic [OPT_WIDTH-1:0]  opt_reg;        // configuration options
  logic [PA_WIDTH-1:0]   wakeEn_reg;     // per-pin wake enables
  logic [PA_WIDTH-1:0]   paSnap_reg;     // pin levels at halt
  logic [INT_COUNT-1:0]  intSnap_reg;    // requests pending at halt
  logic [1:0]            entryCnt_reg;   // service entry delay
  logic                  toFlag_reg;
  logic                  pdFlag_reg;
  logic                  rstMeta_reg;    // synchroniser stages
  logic                  rstSync_reg;
  logic                  lvMeta_reg;
  logic                  lvSync_reg;
  logic [PA_WIDTH-1:0]   paMeta_reg;
  logic [PA_WIDTH-1:0]   paSync_reg;
  logic                  resetActive;    // pin or low-voltage reset held
  logic                  wakePin;
  logic [INT_COUNT-1:0]  newInt;         // requests raised during halt
  logic                  wakeInt;
  logic                  sstStart;
  logic                  sstLong;
  logic                  sstDone;
  logic                  entryDone;
  logic                  resumePulse;
  logic                  servicePulse;
  logic                  warmPulse;
  logic                  haltEntry;
  logic                  dataActive_reg; // bus data phase pending
  logic                  dataWrite_reg;
  logic [7:0]            dataAddr_reg;
  logic                  addrTake;
  logic [31:0]           readMux;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two stages before anything looks at the pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= 1'b1;
      lvMeta_reg  <= 1'b0;
      lvSync_reg  <= 1'b0;
      paMeta_reg  <= '0;
      paSync_reg  <= '0;
    end else if (ce) begin
      rstMeta_reg <= extResetPin_n;
      rstSync_reg <= rstMeta_reg;
      lvMeta_reg  <= lowVoltage;
      lvSync_reg  <= lvMeta_reg;
      paMeta_reg  <= portAPin;
      paSync_reg  <= paMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  // pin reset and low-voltage reset share one path
  assign resetActive = ~rstSync_reg | lvSync_reg;
  // level compare against the halt snapshot, so a short pulse that
  // returns before the clock restarts is the only thing missed
  assign wakePin = |((paSync_reg ^ paSnap_reg) & wakeEn_reg);
  // requests already pending at halt are masked
  assign newInt  = intReq & ~intSnap_reg;
  assign wakeInt = |newInt;
  // long delay unless oscillator kept or rc fast option
  assign sstLong = ~pdc_reg[PDC_OSC_KEEP_BIT]
                 & ~(opt_reg[OPT_RCOSC_BIT] & opt_reg[OPT_SSTFAST_BIT]);
  assign entryDone = (entryCnt_reg == 2'(INT_ENTRY_CYCLES - 1));
  assign haltEntry = (state_reg == ST_RUN) & coreIn.haltExec & ~resetActive;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    cause_next   = cause_reg;
    takeInt_next = takeInt_reg;
    sstStart     = 1'b0;
    resumePulse  = 1'b0;
    servicePulse = 1'b0;
    warmPulse    = 1'b0;
    if (resetActive) begin
      state_next = ST_RESET_HOLD;  // external reset wins over all
      cause_next = CAUSE_NONE;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (coreIn.haltExec) begin
            state_next = ST_HALT;
          end
        end
        ST_HALT: begin
          // wake priority: watchdog, interrupt, port pin
          if (coreIn.wdtOverflow) begin
            state_next = ST_SST;
            cause_next = CAUSE_WDT;
            sstStart   = 1'b1;
          end else if (wakeInt) begin
            state_next   = ST_SST;
            cause_next   = CAUSE_INT;
            // service only if enabled and a stack level is free
            takeInt_next = (|(newInt & intEnable)) & ~coreIn.stackFull;
            sstStart     = 1'b1;
          end else if (wakePin) begin
            state_next = ST_SST;
            cause_next = CAUSE_PIN;
            sstStart   = 1'b1;
          end
        end
        ST_RESET_HOLD: begin
          // a reset that ended a power-down needs the oscillator delay
          if (haltedAtRst_reg) begin
            state_next = ST_SST;
            sstStart   = 1'b1;
          end else begin
            state_next = ST_RUN;
          end
        end
        ST_SST: begin
          if (sstDone) begin
            unique case (cause_reg)
              CAUSE_WDT: begin
                warmPulse  = 1'b1;
                state_next = ST_RUN;
              end
              CAUSE_INT: begin
                if (takeInt_reg) begin
                  state_next = ST_INT_ENTRY;
                end else begin
                  resumePulse = 1'b1;
                  state_next  = ST_RUN;
                end
              end
              CAUSE_PIN: begin
                resumePulse = 1'b1;
                state_next  = ST_RUN;
              end
              CAUSE_NONE: begin
                state_next = ST_RUN;
              end
            endcase
          end
        end
        ST_INT_ENTRY: begin
          if (entryDone) begin
            servicePulse = 1'b1;
            state_next   = ST_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // start-up timer
  // ----------------------------------------------------------------
  hwrs_startup_timer #(
    .LONG_CYCLES  (SST_LONG_CYCLES),
    .SHORT_CYCLES (SST_SHORT_CYCLES)
  ) uStartup (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .start     (sstStart),
    .longDelay (sstLong),
    .done      (sstDone)
  );

  // ----------------------------------------------------------------
  // state, cause and snapshots
  // ----------------------------------------------------------------
  // power-up lands in the start-up delay with a long count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg       <= ST_SST;
      cause_reg       <= CAUSE_NONE;
      takeInt_reg     <= 1'b0;
      haltedAtRst_reg <= 1'b0;
      paSnap_reg      <= '0;
      intSnap_reg     <= '0;
      entryCnt_reg    <= '0;
    end else if (ce) begin
      state_reg   <= state_next;
      cause_reg   <= cause_next;
      takeInt_reg <= takeInt_next;
      // remember whether the reset caught us powered down
      if (resetActive && state_reg != ST_RESET_HOLD) begin
        haltedAtRst_reg <= (state_reg == ST_HALT);
      end
      if (haltEntry) begin
        paSnap_reg  <= paSync_reg;
        intSnap_reg <= intReq;
      end
      entryCnt_reg <= (state_reg == ST_INT_ENTRY) ? entryCnt_reg + 2'h1 : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // power-down and timeout flags
  // ----------------------------------------------------------------
  // pin and low-voltage resets leave both flags untouched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      toFlag_reg <= 1'b0;  // power-up reads 00
      pdFlag_reg <= 1'b0;
    end else if (ce) begin
      if (haltEntry) begin
        pdFlag_reg <= 1'b1;  // set beats a same-cycle clear
      end else if (coreIn.wdtClearExec && state_reg == ST_RUN) begin
        pdFlag_reg <= 1'b0;
      end
      // timeout set wins over the halt clear
      if (coreIn.wdtOverflow && (state_reg == ST_RUN || state_reg == ST_HALT)) begin
        toFlag_reg <= 1'b1;
      end else if (haltEntry) begin
        toFlag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlOut <= '{chipReset: 1'b1, sysOscRun: 1'b1, wdtRun: 1'b0, default: 1'b0};
    end else if (ce) begin
      // core resets pc, interrupts, timers, ports, stack on this level
      // a watchdog time-out in normal running is a chip reset too
      ctrlOut.chipReset <= (state_next == ST_RESET_HOLD)
                         | (coreIn.wdtOverflow & state_reg == ST_RUN);
      ctrlOut.warmReset  <= warmPulse;
      ctrlOut.resumeNext <= resumePulse;
      ctrlOut.intService <= servicePulse;
      // core frozen, memory retained and pins held while halted
      ctrlOut.powerDown <= (state_next == ST_HALT);
      ctrlOut.wdtClear  <= haltEntry;
      // watchdog counts in power-down only on the slow clocks
      ctrlOut.wdtRun    <= (state_next != ST_HALT) | opt_reg[OPT_WDTSLOW_BIT];
      // oscillator stops in power-down unless kept on
      ctrlOut.sysOscRun <= (state_next != ST_HALT) | pdc_reg[PDC_OSC_KEEP_BIT];
      // keep bit overrides the option, both need sub clock
      ctrlOut.lcdRun <= (state_next != ST_HALT)
                      | (opt_reg[OPT_SUBCLK_BIT]
                         & (pdc_reg[PDC_LCD_KEEP_BIT] | opt_reg[OPT_LCDOPT_BIT]));
      ctrlOut.timeoutFlag   <= toFlag_reg;
      ctrlOut.powerdownFlag <= pdFlag_reg;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addrTake = hsel & hready & (htrans == HTRANS_NONSEQ);

  // read value, sampled in the address phase
  always_comb begin
    readMux = 32'h0000_0000;
    unique case (haddr)
      ADDR_PDC:     readMux[7:0] = pdc_reg & PDC_WRITE_MASK;
      ADDR_STATUS: begin
        readMux[STAT_PDF_BIT] = pdFlag_reg;
        readMux[STAT_TO_BIT]  = toFlag_reg;
        readMux[STAT_CAUSE_LSB +: 2] = cause_reg;
        readMux[STAT_HALT_BIT] = (state_reg == ST_HALT);
      end
      ADDR_WAKE_EN: readMux[PA_WIDTH-1:0] = wakeEn_reg;
      ADDR_OPTIONS: readMux[OPT_WIDTH-1:0] = opt_reg;
      default:      readMux = 32'h0000_0000;  // unmapped reads zero
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataActive_reg <= 1'b0;
      dataWrite_reg  <= 1'b0;
      dataAddr_reg   <= 8'h00;
      hrdata         <= 32'h0000_0000;
      hreadyout      <= 1'b1;
      hresp          <= HRESP_OKAY;
    end else if (ce) begin
      if (hready) begin
        dataActive_reg <= addrTake;
        dataWrite_reg  <= hwrite;
        dataAddr_reg   <= haddr;
        if (addrTake && !hwrite) begin
          hrdata <= readMux;
        end
      end
    end
  end

  // register writes in the data phase; hsize is a full word here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdc_reg    <= PDC_RESET;
      wakeEn_reg <= '0;
      opt_reg    <= OPT_RESET;
    end else if (ce) begin
      if (ctrlOut.chipReset) begin
        pdc_reg    <= PDC_RESET;  // cleared by every chip reset
        wakeEn_reg <= '0;
      end else if (dataActive_reg && dataWrite_reg) begin
        unique case (dataAddr_reg)
          ADDR_PDC:     pdc_reg <= hwdata[7:0] & PDC_WRITE_MASK;
          ADDR_WAKE_EN: wakeEn_reg <= hwdata[PA_WIDTH-1:0];
          ADDR_OPTIONS: opt_reg <= hwdata[OPT_WIDTH-1:0];
          default:      ;  // unmapped or read-only, ignored
        endcase
      end
    end
  end

endmodule

/* logic/hwrs_pkg.sv */
// Overview of operation
// - halt enters power-down; oscillator per keep bit
// - memory and registers retained while powered down
// - watchdog cleared at halt, recounts on slow clock
// - port pins keep direction and level
// - halt sets powerdown flag, clears timeout flag
// - LCD runs only with sub clock and keep bit or option
// - exit by reset, interrupt, port pin, watchdog
// - powerdown flag cleared by power-up or clear instruction
// - watchdog wake sets timeout, warm resets PC, SP
// - per-pin port A wake enables; resume next
// - interrupt wake: resume next or take service
// - request pending before halt cannot wake
// - start-up delay 1024 or 2 clock periods
// - next instruction at once; service entry later
// - bit 0 keeps Lcd_powerdown_option, else option decides
// - bit 7 keeps system oscillator running
// - bits 1 to 6 read as zero
// - four reset sources recognised
// - timeout/powerdown pair encodes reset cause
// - start-up delay at power-up and every wake
// - chip reset puts core units in reset state
package hwrs_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PDC     = 8'h00;  // power_down_control
  localparam logic [7:0] ADDR_STATUS  = 8'h04;  // flags and sequencer state
  localparam logic [7:0] ADDR_WAKE_EN = 8'h08;  // port A wake enables
  localparam logic [7:0] ADDR_OPTIONS = 8'h0C;  // configuration options

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int         PDC_LCD_KEEP_BIT = 0;      // lcd_keep_on
  localparam int         PDC_OSC_KEEP_BIT = 7;      // sysosc_keep_on
  localparam logic [7:0] PDC_WRITE_MASK   = 8'h81;  // reserved bits stay zero
  localparam logic [7:0] PDC_RESET        = 8'h00;
  localparam int         OPT_WIDTH        = 5;
  localparam int         OPT_SUBCLK_BIT   = 0;      // sub_clock_enable
  localparam int         OPT_LCDOPT_BIT   = 1;      // lcd_powerdown_option
  localparam int         OPT_RCOSC_BIT    = 2;      // rc type system oscillator
  localparam int         OPT_SSTFAST_BIT  = 3;      // rc start-up option
  localparam int         OPT_WDTSLOW_BIT  = 4;      // watchdog on slow clock
  localparam logic [4:0] OPT_RESET        = 5'h00;
  localparam int         STAT_PDF_BIT     = 0;
  localparam int         STAT_TO_BIT      = 1;
  localparam int         STAT_CAUSE_LSB   = 2;
  localparam int         STAT_HALT_BIT    = 4;

  // ----------------------------------------------------------------
  // timing counts in system clock periods
  // ----------------------------------------------------------------
  localparam int SST_LONG_CYCLES  = 1024;
  localparam int SST_SHORT_CYCLES = 2;
  localparam int INT_ENTRY_CYCLES = 2;  // service entry lags by more than one

  // ----------------------------------------------------------------
  // bus codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {ST_RUN, ST_HALT, ST_RESET_HOLD, ST_SST, ST_INT_ENTRY} hwrs_state_type;
  typedef enum logic [1:0] {CAUSE_NONE, CAUSE_PIN, CAUSE_INT, CAUSE_WDT} hwrs_cause_type;

  typedef struct packed {
    logic haltExec;      // halt instruction executed, pulse
    logic wdtClearExec;  // watchdog clear instruction, pulse
    logic wdtOverflow;   // watchdog time-out, pulse
    logic stackFull;     // call stack has no free level
  } hwrs_core_in_type;

  typedef struct packed {
    logic chipReset;      // full initialisation, level
    logic warmReset;      // program counter and stack pointer only, pulse
    logic resumeNext;     // continue after the halt, pulse
    logic intService;     // enter interrupt service, pulse
    logic powerDown;      // core frozen, memory and pins held
    logic wdtClear;       // clear watchdog counter, pulse
    logic wdtRun;         // watchdog may count
    logic sysOscRun;      // system oscillator enable
    logic lcdRun;         // LCD driver enable
    logic timeoutFlag;
    logic powerdownFlag;
  } hwrs_ctrl_out_type;

endpackage

/* logic/hwrs_startup_timer.sv */
`timescale 1ns/1ps
module hwrs_startup_timer
  import hwrs_pkg::*;
#(
  parameter int LONG_CYCLES  = SST_LONG_CYCLES,
  parameter int SHORT_CYCLES = SST_SHORT_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // control
  input  wire logic start,      // load and begin counting
  input  wire logic longDelay,  // pick the long count
  // status
  output logic      done        // one cycle at the end of the delay
);

  localparam int CW = $clog2(LONG_CYCLES + 1);

  if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) begin : gBadCount
    $error("startup timer counts out of range");
  end

  logic [CW-1:0] count_reg;  // cycles left
  logic          busy_reg;   // delay running

  // ----------------------------------------------------------------
  // down counter; a start during a run reloads it
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // power-up opens with the long delay already running
      count_reg <= CW'(LONG_CYCLES);
      busy_reg  <= 1'b1;
      done      <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        // delay length picked at load time
        count_reg <= longDelay ? CW'(LONG_CYCLES) : CW'(SHORT_CYCLES);
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        count_reg <= count_reg - CW'(1);
        if (count_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule

/* test/hwrs_checker_assertions.sv */
`timescale 1ns/1ps
module hwrs_checker
  import hwrs_pkg::*;
(
  // clock, reset and bus
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              ce,
  input wire logic              hsel,
  input wire logic [7:0]        haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  // core side
  input wire hwrs_core_in_type  coreIn,
  input wire hwrs_ctrl_out_type ctrlOut
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic haltOk;  // halt outside power-down and chip reset; halts in start-up are included
  logic fin;     // any kind of resume
  assign haltOk = coreIn.haltExec && !ctrlOut.powerDown && !ctrlOut.chipReset;
  assign fin = ctrlOut.resumeNext || ctrlOut.warmReset || ctrlOut.intService;
  logic        pdPrev;   // powerDown one enabled cycle ago
  logic [10:0] wakeCnt;  // enabled cycles since power-down ended, 0 when idle
  // a counter, since the longest wake outruns any delay range
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdPrev  <= 1'b0;
      wakeCnt <= 11'h000;
    end else if (ce) begin
      pdPrev <= ctrlOut.powerDown;
      if (fin || ctrlOut.chipReset || ctrlOut.powerDown) begin
        wakeCnt <= 11'h000;
      end else if ((pdPrev || wakeCnt != 11'h000) && wakeCnt != 11'h7FF) begin
        wakeCnt <= wakeCnt + 11'h001;
      end
    end
  end
  a_halt_enter: assert property (haltOk |=> ctrlOut.powerDown && ctrlOut.wdtClear)
    else $error("halt not entered");
  a_halt_flags: assert property (haltOk |-> ##2 ctrlOut.powerdownFlag && !ctrlOut.timeoutFlag)
    else $error("halt flags wrong");
  a_pdf_hold: assert property (ctrlOut.powerDown && $past(ctrlOut.powerDown, 2)
    |-> $stable(ctrlOut.powerdownFlag)) else $error("flag moved in halt");
  a_wake_quiet: assert property ($fell(ctrlOut.powerDown) |-> !fin [*3])
    else $error("resume before start-up delay");
  a_wake_bound: assert property (wakeCnt <= 11'h405)
    else $error("no resume after wake");
  a_warm_flags: assert property ($rose(ctrlOut.warmReset) |-> ctrlOut.timeoutFlag
    && ctrlOut.powerdownFlag) else $error("warm reset flags wrong");
  a_clear_pdf: assert property (coreIn.wdtClearExec && !coreIn.haltExec
    && !ctrlOut.powerDown |-> ##2 !ctrlOut.powerdownFlag) else $error("flag not cleared");
  a_pdc_read: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
    && haddr == ADDR_PDC |=> (hrdata & 32'hFFFFFF7E) == 32'h0) else $error("reserved bits set");
  c_pin: cover property ($rose(ctrlOut.resumeNext));
  c_int: cover property ($rose(ctrlOut.intService));
  c_warm: cover property ($rose(ctrlOut.warmReset));
endmodule

bind hwrs_sequencer hwrs_checker i_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .coreIn(coreIn), .ctrlOut(ctrlOut));

/* test/hwrs_core_model.sv */
`timescale 1ns/1ps
module hwrs_core_model
  import hwrs_pkg::*;
(
  // clock and answers
  input wire logic              clk,
  input wire hwrs_ctrl_out_type ctrlOut,
  // core requests
  output hwrs_core_in_type      coreIn,
  output logic [3:0]            intReq,
  output logic [3:0]            intEnable
);
  initial begin
    coreIn = '0;
    intReq = 4'h0;
    intEnable = 4'h0;
  end
  // one-cycle instruction strobe: 3 halt, 2 clear, 1 overflow
  task automatic fire(input int b);
    @(posedge clk) coreIn[b] <= 1'b1;
    @(posedge clk) coreIn[b] <= 1'b0;
  endtask
  // service entry acknowledges the enabled requests only
  always @(posedge clk) begin
    if (ctrlOut.intService) begin
      intReq <= intReq & ~intEnable;
    end
  end
endmodule

/* test/halt_wakeup_reset_sequencer_bench.sv */
`timescale 1ns/1ps
module halt_wakeup_reset_sequencer_bench
  import hwrs_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic              extResetPin_n = 1'b1;
  logic              ce = 1'b1;
  logic              lowVoltage = 1'b0;
  logic [7:0]        haddr = 8'h00;
  logic [7:0]        portAPin = 8'h00;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       hrdata;
  logic [31:0]       rd;  // last read word
  logic              hreadyout;
  logic              hresp;
  logic [3:0]        intReq;
  logic [3:0]        intEnable;
  logic [10:0]       co;  // ctrlOut as bits, chipReset at 10
  hwrs_core_in_type  coreIn;
  hwrs_ctrl_out_type ctrlOut;
  int                errors = 0;
  int                check_count = 0;
  int                n;
  assign co = ctrlOut;
  always #2.5 clk = ~clk;
  hwrs_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .coreIn(coreIn), .intReq(intReq),
    .intEnable(intEnable), .ctrlOut(ctrlOut), .extResetPin_n(extResetPin_n),
    .lowVoltage(lowVoltage), .portAPin(portAPin));
  hwrs_core_model i_core (.clk(clk), .ctrlOut(ctrlOut), .coreIn(coreIn), .intReq(intReq),
    .intEnable(intEnable));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for a ctrlOut bit; a hang counts as a mismatch
  task automatic waitbit(input int b, input int lim);
    n = 0;
    while (co[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) chk(32'h0, 32'h1);
    if (n >= lim) close_out();
  endtask
  // one single ahb transfer; idle cycle first avoids stale reads
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    waitbus();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    waitbus();
    rd = hrdata;
  endtask
  task automatic waitbus();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h0, 32'h1);
    if (k >= 50) close_out();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    chk({co[10], co[3]}, 2'b11);
    sys_rst <= 1'b0;
    bus(1'b0, ADDR_PDC, 32'h0);
    chk(rd, 32'h0);
    repeat (1100) @(posedge clk);
    bus(1'b1, ADDR_PDC, 32'hFFFFFFFF);
    bus(1'b0, ADDR_PDC, 32'h0);
    chk(rd, 32'h81);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, ADDR_OPTIONS, 32'h1);
    bus(1'b1, ADDR_WAKE_EN, 32'h1);
    i_core.fire(3);
    repeat (3) @(posedge clk);
    chk({co[6], co[3:0]}, 5'b11101);
    portAPin <= 8'h02;
    repeat (20) @(posedge clk);
    chk(co[6], 1'b1);
    portAPin <= 8'h03;
    waitbit(8, 40);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[4:0], 5'h05);
    bus(1'b1, ADDR_PDC, 32'h0);
    i_core.fire(3);
    repeat (3) @(posedge clk);
    chk({co[6], co[4:2]}, 4'b1000);
    i_core.fire(1);
    // a frozen clock enable must stretch the delay by the frozen cycles
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    ce <= 1'b1;
    waitbit(9, 1100);
    chk(n >= 1024 && n < 1030, 1'b1);
    chk(co[1:0], 2'b11);
    bus(1'b1, ADDR_PDC, 32'h80);
    i_core.intReq <= 4'h1;
    i_core.intEnable <= 4'h3;
    i_core.fire(3);
    repeat (20) @(posedge clk);
    chk(co[6], 1'b1);
    i_core.intReq <= 4'h3;
    waitbit(7, 40);
    // disabled source, then enabled with a full stack
    for (int k = 0; k < 2; k++) begin
      i_core.intEnable <= k ? 4'h4 : 4'h0;
      i_core.coreIn[0] <= k[0];
      repeat (4) @(posedge clk);
      i_core.fire(3);
      repeat (5) @(posedge clk);
      i_core.intReq <= 4'h4;
      waitbit(8, 40);
      i_core.intReq <= 4'h0;
    end
    repeat (4) @(posedge clk);
    i_core.fire(2);
    repeat (3) @(posedge clk);
    chk(co[0], 1'b0);
    i_core.fire(1);
    waitbit(10, 5);
    repeat (3) @(posedge clk);
    chk(co[1:0], 2'b10);
    // pin reset, then low-voltage reset, both while running
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_PDC, 32'h81);
      {lowVoltage, extResetPin_n} <= k ? 2'b11 : 2'b00;
      waitbit(10, 10);
      chk(co[1:0], 2'b10);
      {lowVoltage, extResetPin_n} <= 2'b01;
      repeat (10) @(posedge clk);
    end
    bus(1'b0, ADDR_PDC, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
